// ### common/pdr_consts.svh
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH

// Register byte addresses on the bus.
`define PDR_ADDR_CTRL_B 12'h000
`define PDR_ADDR_CTRL_C 12'h004

// Field positions in the second disable register.
`define PDR_B_SERIAL4_BIT 5
`define PDR_B_REFCLK_BIT 3
`define PDR_B_CHARGE_BIT 2

// Field positions in the third disable register.
`define PDR_C_PWM_LSB 8
`define PDR_C_PWM_COUNT 6
`define PDR_C_SPI3_BIT 0

// Writable masks and reset values.
`define PDR_B_MASK 16'h002c
`define PDR_C_MASK 16'h3f01
`define PDR_B_RESET 16'h0000
`define PDR_C_RESET 16'h0000

// Bus response codes.
`define PDR_RESP_OKAY 2'h0
`define PDR_RESP_SLVERR 2'h2

`endif

// ### common/pdr_pkg.sv
package pdr_pkg;

    // Disable lines grouped by the register they come from.
    typedef struct packed {
        logic serial_port_four_off;
        logic ref_clock_out_off;
        logic charge_timer_unit_off;
    } pdr_ctrl_b_t;

    typedef struct packed {
        logic [5:0] pwm_gen_off;
        logic serial_periph_three_off;
    } pdr_ctrl_c_t;

endpackage

// ### logic/pdr_reg_field.sv
`timescale 1ns/1ps
`include "pdr_consts.svh"

// One 16-bit register whose writable bits are chosen by a mask.
module pdr_reg_field #(
    parameter logic [15:0] MASK = 16'h0000,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic [15:0] value
);

    logic [15:0] value_q;
    logic [15:0] lane_mask;

    // Byte enables select which half of the register a write may touch.
    assign lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}} & MASK;

    // Unimplemented bits keep their reset zero whatever is written.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            value_q <= RESET_VAL;
        end else if (wr_en) begin
            value_q <= (value_q & ~lane_mask) | (wdata[15:0] & lane_mask);
        end
    end

    assign value = value_q;

endmodule

// ### logic/pdr_regs.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pdr_consts.svh"

// What this block does
// [RULE1] Second register bit 3 turns off the reference clock output when set.
// [RULE2] Third register bits 13..8 turn off PWM generators one to six.
// [RULE3] Third register bit 0 turns off the third SPI port when set.
// [RULE4] Unimplemented bits in both registers read zero and ignore writes.
// [RULE5] Power-on reset clears every disable bit, leaving all peripherals enabled.
// [RULE6] Implemented bits are read/write and read back the last written value.
// [RULE7] Second register bit 5 stops serial port four, bit 2 the charge timer.
module pdr_regs (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output pdr_pkg::pdr_ctrl_b_t ctrl_b_off,
    output pdr_pkg::pdr_ctrl_c_t ctrl_c_off
);
    import pdr_pkg::*;

    logic aw_held_q;
    logic aw_held_d;
    logic w_held_q;
    logic w_held_d;
    logic bvalid_d;
    logic rvalid_d;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic wr_b;
    logic wr_c;
    logic rd_b;
    logic rd_c;
    logic [15:0] reg_b;
    logic [15:0] reg_c;
    logic [31:0] rdata_d;
    logic [1:0] rresp_d;
    pdr_ctrl_b_t ctrl_b_q;
    pdr_ctrl_c_t ctrl_c_q;

    // A channel moves at the edge where its valid meets the registered ready.
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // Address and data are caught in either order; the write fires once both are held.
    // Holding off while an answer waits keeps at most one write in flight.
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    // Decode on the word index; the two low address bits are ignored.
    assign wr_b = do_write && (awaddr_q[11:2] == 10'(`PDR_ADDR_CTRL_B >> 2));
    assign wr_c = do_write && (awaddr_q[11:2] == 10'(`PDR_ADDR_CTRL_C >> 2));
    assign rd_b = (s_axi_araddr[11:2] == 10'(`PDR_ADDR_CTRL_B >> 2));
    assign rd_c = (s_axi_araddr[11:2] == 10'(`PDR_ADDR_CTRL_C >> 2));

    // Next values of the handshake state.
    // The readies are registered from these, so they come from flops yet move on the cycle a gate would.
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        bvalid_d = s_axi_bvalid;
        rvalid_d = s_axi_rvalid;
        if (aw_take) begin
            aw_held_d = 1'b1;
        end else if (do_write) begin
            aw_held_d = 1'b0;
        end
        if (w_take) begin
            w_held_d = 1'b1;
        end else if (do_write) begin
            w_held_d = 1'b0;
        end
        if (do_write) begin
            bvalid_d = 1'b1;
        end else if (s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (ar_take) begin
            rvalid_d = 1'b1;
        end else if (s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Ready outputs are low while their channel is held or an answer still waits.
    // They are high out of reset, since nothing is held then.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_awready <= !aw_held_d && !bvalid_d;
            s_axi_wready <= !w_held_d && !bvalid_d;
            s_axi_arready <= !rvalid_d;
        end
    end

    // Write address, kept from its handshake until the write fires.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 12'h000;
        end else begin
            aw_held_q <= aw_held_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
        end
    end

    // Write data and strobes, kept from their handshake until the write fires.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            w_held_q <= w_held_d;
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR and change nothing.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDR_RESP_OKAY;
        end else begin
            s_axi_bvalid <= bvalid_d;
            if (do_write) begin
                s_axi_bresp <= (wr_b || wr_c) ? `PDR_RESP_OKAY : `PDR_RESP_SLVERR;
            end
        end
    end

    // The second register only stores bits 5, 3 and 2.
    pdr_reg_field #(
        .MASK(`PDR_B_MASK), // [RULE4] [RULE6]
        .RESET_VAL(`PDR_B_RESET) // [RULE5]
    ) u_reg_b (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_b),
        .wdata(wdata_q),
        .wstrb(wstrb_q),
        .value(reg_b)
    );

    // The third register only stores bits 13..8 and 0.
    pdr_reg_field #(
        .MASK(`PDR_C_MASK), // [RULE4] [RULE6]
        .RESET_VAL(`PDR_C_RESET) // [RULE5]
    ) u_reg_c (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_c),
        .wdata(wdata_q),
        .wstrb(wstrb_q),
        .value(reg_c)
    );

    // Read mux; narrow registers sit in the low half, upper bits read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        rresp_d = `PDR_RESP_OKAY;
        if (rd_b) begin
            rdata_d = {16'h0000, reg_b}; // [RULE4] [RULE6]
        end else if (rd_c) begin
            rdata_d = {16'h0000, reg_c}; // [RULE4] [RULE6]
        end else begin
            rresp_d = `PDR_RESP_SLVERR;
        end
    end

    // Reads answer one cycle after the address is taken; the answer stands until rready.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PDR_RESP_OKAY;
        end else begin
            s_axi_rvalid <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rresp_d;
            end
        end
    end

    // Disable lines are registered copies so that the outputs come from flops; they lag the stored bits by one cycle.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_b_q <= '0; // [RULE5]
            ctrl_c_q <= '0; // [RULE5]
        end else begin
            ctrl_b_q.serial_port_four_off <= reg_b[`PDR_B_SERIAL4_BIT]; // [RULE7]
            ctrl_b_q.ref_clock_out_off <= reg_b[`PDR_B_REFCLK_BIT]; // [RULE1]
            ctrl_b_q.charge_timer_unit_off <= reg_b[`PDR_B_CHARGE_BIT]; // [RULE7]
            ctrl_c_q.pwm_gen_off <= reg_c[`PDR_C_PWM_LSB +: `PDR_C_PWM_COUNT]; // [RULE2]
            ctrl_c_q.serial_periph_three_off <= reg_c[`PDR_C_SPI3_BIT]; // [RULE3]
        end
    end

    assign ctrl_b_off = ctrl_b_q;
    assign ctrl_c_off = ctrl_c_q;

endmodule

// ### tb/pdr_regs_chk.sv
`timescale 1ns/1ps
// Watches the bus answers and the disable lines of the register bank.
module pdr_regs_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pdr_pkg::pdr_ctrl_b_t ctrl_b_off,
    input wire pdr_pkg::pdr_ctrl_c_t ctrl_c_off
);
    import pdr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic [9:0] offs = {ctrl_b_off, ctrl_c_off};
    // A taken read request, which must be answered on the next edge.
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_RD_ANSWER: assert property (s_ar |=> s_axi_rvalid)
        else $error("Read not answered");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken while busy");
    AST_RD_ZERO: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffffc0d2) == 32'h0)
        else $error("Unused bits read high");
    AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
        else $error("Refused read has data");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write answer dropped");
    // The lines may only move one or two edges after a write answer, never on their own.
    AST_OUT_CAUSE: assert property ($changed(offs) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("Disable lines moved alone");
    AST_RST_CLEAR: assert property ($rose(resetn) |-> offs == 10'h000)
        else $error("Disable lines not clear");
endmodule

bind pdr_regs pdr_regs_chk u_chk (.*);

// ### tb/peripheral_disable_regs_bench.sv
`timescale 1ns/1ps
`include "pdr_consts.svh"
module peripheral_disable_regs_bench;
    import pdr_pkg::*;
    logic clock = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    pdr_ctrl_b_t ctrl_b_off;
    pdr_ctrl_c_t ctrl_c_off;
    int n_fail = 0, checks_done = 0;
    // Rows: address, data, strobes, read-back, then both disable outputs side by side.
    logic [11:0] t_a [6] = '{12'h000, 12'h004, 12'h000, 12'h004, 12'h004, 12'h000};
    logic [31:0] t_d [6] = '{32'hffffffff, 32'hffffffff, 32'h8, 32'h500, 32'hff00, 32'hffd3};
    logic [3:0] t_s [6] = '{4'hf, 4'hf, 4'hf, 4'h2, 4'h1, 4'hf};
    logic [31:0] t_r [6] = '{32'h2c, 32'h3f01, 32'h8, 32'h501, 32'h500, 32'h0};
    logic [9:0] t_o [6] = '{10'h380, 10'h3ff, 10'h17f, 10'h10b, 10'h10a, 10'h00a};
    pdr_regs u_dut (.*);
    // System clock.
    initial begin
        forever #5 clock = ~clock;
    end
    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // Compares the response code of the last bus transfer.
    task automatic chk_resp(input logic [1:0] e);
        chk(32'(resp), 32'(e));
    endtask
    // Compares the ten disable lines, second register above third.
    task automatic chk_offs(input logic [9:0] e);
        chk(32'({ctrl_b_off, ctrl_c_off}), 32'(e));
    endtask
    // Ready is raised late on purpose so the slave must hold its answer.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Main sequence: table rows first, then the unmapped and reset cases.
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 6; i++) begin
            wr(t_a[i], t_d[i], t_s[i]);
            chk_resp(`PDR_RESP_OKAY);
            rd(t_a[i]);
            chk_resp(`PDR_RESP_OKAY);
            chk(got, t_r[i]);
            chk_offs(t_o[i]);
        end
        $display("Table test done");
        wr(12'h008, 32'hffffffff, 4'hf);
        chk_resp(`PDR_RESP_SLVERR);
        rd(12'h008);
        chk_resp(`PDR_RESP_SLVERR);
        rd(12'h004);
        chk(got, 32'h500);
        $display("Unmapped test done");
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        chk_offs(10'h000);
        resetn <= 1'b1;
        @(posedge clock);
        rd(12'h004);
        chk(got, 32'h0);
        $display("Reset test done");
        print_verdict();
    end
    // The run needs well under a hundred cycles, so this limit only trips on a hang.
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        print_verdict();
    end
endmodule
